// ===== hdl/exec_defines.svh
// Overview of operation
// RQ1: Exclusive OR of two registers into destination, updates Z N V S, one cycle.
// RQ2: OR immediate mask into destination, updates Z N V S, one cycle.
// RQ3: AND destination with inverted immediate mask, updates Z N V S, one cycle.
// RQ4: Add one to register, updates Z N V S, carry kept, one cycle.
// RQ5: Subtract one from register, updates Z N V S, carry kept, one cycle.
// RQ6: Probe register against itself, value intact, updates Z N V S, one cycle.
// RQ7: Zero a register by self XOR, updates Z N V S, one cycle.
// RQ8: Relative jump loads PC plus offset plus one, no flags, two cycles.
// RQ9: Pointer jump loads PC from Z pointer, upper bits cleared, two cycles.
// RQ10: Relative or pointer calls set target as jumps, no flags, three cycles.
// RQ11: Compare-skip skips next instruction when registers equal, 1, 2 or 3 cycles.
// RQ12: Register bit skips on bit low or high, 1, 2 or 3 cycles, no flags.
// RQ13: I/O bit skips on bit low or high, 1, 2 or 3 cycles, no flags.
// RQ14: Flag branches test selected flag bit, take relative target, 1 or 2 cycles.
// RQ15: Equal and unequal branches test the zero flag, 1 or 2 cycles.
// RQ16: Carry branches test the carry flag, no flags changed, 1 or 2 cycles.
// RQ17: Failed conditions use the lowest count, changes and long skips use more.
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ==========================================================
// Register offsets
`define ADDR_CTRL       12'h000
`define ADDR_INSTR      12'h004
`define ADDR_OFFSET     12'h008
`define ADDR_PC         12'h00C
`define ADDR_FLAGS      12'h010
`define ADDR_ZPTR       12'h014
`define ADDR_IODATA     12'h018
`define ADDR_STATUS     12'h01C
`define ADDR_RETADDR    12'h020
`define GPR_PAGE        6'h01

// ==========================================================
// Field positions
`define CTRL_START      0
`define CTRL_LONG       1
`define INSTR_OP_LSB    0
`define INSTR_DST_LSB   8
`define INSTR_SRC_LSB   12
`define INSTR_IMM_LSB   16
`define INSTR_BSEL_LSB  24
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_N          2
`define FLAG_V          3
`define FLAG_S          4

// ==========================================================
// Reset values
`define PC_RST          22'h00_0000
`define FLAGS_RST       8'h00

// ==========================================================
// Cycle counts
`define CYC_ONE         3'h1
`define CYC_JUMP        3'h2
`define CYC_CALL        3'h3
`define CYC_SKIP_SHORT  3'h2
`define CYC_SKIP_LONG   3'h3

`endif

// ===== hdl/exec_pkg.sv
package exec_pkg;

   typedef enum logic [4:0] {
      xor_registers,
      or_mask_into_register,
      and_out_mask_bits,
      add_one_to_register,
      subtract_one_from_register,
      probe_zero_or_negative,
      zero_register,
      relative_jump,
      pointer_jump,
      relative_subroutine_call,
      pointer_subroutine_call,
      compare_skip_equal,
      skip_if_reg_bit_low,
      skip_if_reg_bit_high,
      skip_if_io_bit_low,
      skip_if_io_bit_high,
      jump_if_flag_high,
      jump_if_flag_low,
      jump_if_equal,
      jump_if_unequal,
      jump_if_carry_high,
      jump_if_carry_low
   } op_t;

   typedef enum logic {
      st_idle,
      st_exec
   } state_t;

   function automatic logic is_logic_op(input op_t op);
      is_logic_op = (op <= zero_register);
   endfunction

   function automatic logic is_call_op(input op_t op);
      is_call_op = (op == relative_subroutine_call) || (op == pointer_subroutine_call);
   endfunction

endpackage

// ===== hdl/alu_flags.sv
`timescale 1ns/10ps
`include "exec_defines.svh"

module alu_flags (
   input  wire exec_pkg::op_t op,
   input  wire logic [7:0]    a,
   input  wire logic [7:0]    b,
   input  wire logic [7:0]    imm,
   input  wire logic [7:0]    flags_in,
   output logic [7:0]         result,
   output logic [7:0]         flags_out,
   output logic               writes
);

   logic v;

   always_comb begin
      result = a;
      v      = 1'b0;
      writes = 1'b1;
      case (op)
         exec_pkg::xor_registers:              result = a ^ b;    // RQ1
         exec_pkg::or_mask_into_register:      result = a | imm;  // RQ2
         exec_pkg::and_out_mask_bits:          result = a & ~imm; // RQ3
         exec_pkg::add_one_to_register: begin
            result = a + 8'h01;                                  // RQ4
            v      = (a == 8'h7F);
         end
         exec_pkg::subtract_one_from_register: begin
            result = a - 8'h01;                                  // RQ5
            v      = (a == 8'h80);
         end
         exec_pkg::probe_zero_or_negative: begin
            result = a & a;                                      // RQ6
            writes = 1'b0;
         end
         exec_pkg::zero_register:              result = a ^ a;    // RQ7
         default:                              writes = 1'b0;
      endcase
   end

   // Carry, H, T, I kept; Z N V S from result
   always_comb begin
      flags_out = flags_in;
      if (exec_pkg::is_logic_op(op)) begin
         flags_out[`FLAG_Z] = (result == 8'h00);
         flags_out[`FLAG_N] = result[7];
         flags_out[`FLAG_V] = v;
         flags_out[`FLAG_S] = result[7] ^ v;
      end
   end

endmodule

// ===== hdl/pc_target.sv
`timescale 1ns/10ps
`include "exec_defines.svh"

module pc_target (
   input  wire exec_pkg::op_t op,
   input  wire logic [21:0]   pc,
   input  wire logic [11:0]   k,
   input  wire logic [15:0]   zptr,
   input  wire logic [7:0]    flags,
   input  wire logic [7:0]    a,
   input  wire logic [7:0]    b,
   input  wire logic [7:0]    io_val,
   input  wire logic [2:0]    bsel,
   input  wire logic          next_long,
   output logic [21:0]        target,
   output logic               taken,
   output logic [2:0]         cycles
);

   logic [21:0] rel;
   logic [21:0] seq;
   logic [21:0] ptr;
   logic        is_skip;
   logic        is_branch;
   logic        cond;

   assign rel = pc + {{10{k[11]}}, k} + 22'h00_0001;
   assign seq = pc + 22'h00_0001;
   assign ptr = {6'h00, zptr};

   always_comb begin
      is_skip   = 1'b0;
      is_branch = 1'b0;
      cond      = 1'b0;
      case (op)
         exec_pkg::compare_skip_equal: begin
            is_skip = 1'b1;
            cond    = (a == b);                                  // RQ11
         end
         exec_pkg::skip_if_reg_bit_low: begin
            is_skip = 1'b1;
            cond    = ~a[bsel];                                  // RQ12
         end
         exec_pkg::skip_if_reg_bit_high: begin
            is_skip = 1'b1;
            cond    = a[bsel];                                   // RQ12
         end
         exec_pkg::skip_if_io_bit_low: begin
            is_skip = 1'b1;
            cond    = ~io_val[bsel];                             // RQ13
         end
         exec_pkg::skip_if_io_bit_high: begin
            is_skip = 1'b1;
            cond    = io_val[bsel];                              // RQ13
         end
         exec_pkg::jump_if_flag_high: begin
            is_branch = 1'b1;
            cond      = flags[bsel];                             // RQ14
         end
         exec_pkg::jump_if_flag_low: begin
            is_branch = 1'b1;
            cond      = ~flags[bsel];                            // RQ14
         end
         exec_pkg::jump_if_equal: begin
            is_branch = 1'b1;
            cond      = flags[`FLAG_Z];                          // RQ15
         end
         exec_pkg::jump_if_unequal: begin
            is_branch = 1'b1;
            cond      = ~flags[`FLAG_Z];                         // RQ15
         end
         exec_pkg::jump_if_carry_high: begin
            is_branch = 1'b1;
            cond      = flags[`FLAG_C];                          // RQ16
         end
         exec_pkg::jump_if_carry_low: begin
            is_branch = 1'b1;
            cond      = ~flags[`FLAG_C];                         // RQ16
         end
         default: cond = 1'b0;
      endcase
   end

   always_comb begin
      target = seq;
      taken  = 1'b0;
      cycles = `CYC_ONE;
      case (op)
         exec_pkg::relative_jump: begin
            target = rel;                                        // RQ8
            taken  = 1'b1;
            cycles = `CYC_JUMP;
         end
         exec_pkg::pointer_jump: begin
            target = ptr;                                        // RQ9
            taken  = 1'b1;
            cycles = `CYC_JUMP;
         end
         exec_pkg::relative_subroutine_call: begin
            target = rel;                                        // RQ10
            taken  = 1'b1;
            cycles = `CYC_CALL;
         end
         exec_pkg::pointer_subroutine_call: begin
            target = ptr;                                        // RQ10
            taken  = 1'b1;
            cycles = `CYC_CALL;
         end
         default: begin
            if (is_skip && cond) begin
               taken  = 1'b1;                                    // RQ17
               target = next_long ? pc + 22'h00_0003 : pc + 22'h00_0002;
               cycles = next_long ? `CYC_SKIP_LONG : `CYC_SKIP_SHORT;
            end else if (is_branch && cond) begin
               taken  = 1'b1;                                    // RQ17
               target = rel;
               cycles = `CYC_JUMP;
            end
         end
      endcase
   end

endmodule

// ===== hdl/logic_and_branch_execution.sv
`timescale 1ns/10ps
`include "exec_defines.svh"

module logic_and_branch_execution (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             busy
);

   // ==========================================================
   // Architectural state
   logic [7:0]       gpr [16];
   logic [21:0]      pc;
   logic [7:0]       flag_register;
   logic [15:0]      zptr;
   logic [7:0]       io_reg;
   logic [31:0]      instr;
   logic [11:0]      offset;
   logic             next_long;
   logic [21:0]      ret_addr;
   logic [2:0]       last_cycles;
   logic             last_taken;

   // ==========================================================
   // Execution state
   exec_pkg::state_t state;
   logic [2:0]       cnt;
   exec_pkg::op_t    cur_op;
   logic [3:0]       cur_dst;
   logic [7:0]       lat_a;
   logic [7:0]       lat_b;
   logic [7:0]       pend_res;
   logic [7:0]       pend_flags;
   logic [21:0]      pend_pc;
   logic             pend_wr;

   // ==========================================================
   // Instruction decode
   wire exec_pkg::op_t dec_op   = exec_pkg::op_t'(instr[`INSTR_OP_LSB +: 5]);
   wire logic [3:0]    dec_dst  = instr[`INSTR_DST_LSB +: 4];
   wire logic [3:0]    dec_src  = instr[`INSTR_SRC_LSB +: 4];
   wire logic [7:0]    dec_imm  = instr[`INSTR_IMM_LSB +: 8];
   wire logic [2:0]    dec_bsel = instr[`INSTR_BSEL_LSB +: 3];
   wire logic [7:0]    op_a     = gpr[dec_dst];
   wire logic [7:0]    op_b     = gpr[dec_src];

   logic [7:0]  alu_res;
   logic [7:0]  alu_flags_out;
   logic        alu_writes;
   logic [21:0] next_pc;
   logic        flow_taken;
   logic [2:0]  cycles;

   alu_flags u_alu (
      .op        (dec_op),
      .a         (op_a),
      .b         (op_b),
      .imm       (dec_imm),
      .flags_in  (flag_register),
      .result    (alu_res),
      .flags_out (alu_flags_out),
      .writes    (alu_writes)
   );

   pc_target u_pc (
      .op        (dec_op),
      .pc        (pc),
      .k         (offset),
      .zptr      (zptr),
      .flags     (flag_register),
      .a         (op_a),
      .b         (op_b),
      .io_val    (io_reg),
      .bsel      (dec_bsel),
      .next_long (next_long),
      .target    (next_pc),
      .taken     (flow_taken),
      .cycles    (cycles)
   );

   // ==========================================================
   // APB decode
   wire logic setup    = psel & ~penable;
   wire logic access   = psel & penable & pready;
   wire logic hit_ctrl = (paddr == `ADDR_CTRL);
   wire logic hit_ins  = (paddr == `ADDR_INSTR);
   wire logic hit_off  = (paddr == `ADDR_OFFSET);
   wire logic hit_pc   = (paddr == `ADDR_PC);
   wire logic hit_flg  = (paddr == `ADDR_FLAGS);
   wire logic hit_z    = (paddr == `ADDR_ZPTR);
   wire logic hit_io   = (paddr == `ADDR_IODATA);
   wire logic hit_st   = (paddr == `ADDR_STATUS);
   wire logic hit_ret  = (paddr == `ADDR_RETADDR);
   wire logic hit_gpr  = (paddr[11:6] == `GPR_PAGE) && (paddr[1:0] == 2'h0);
   wire logic mapped   = hit_ctrl | hit_ins | hit_off | hit_pc | hit_flg | hit_z
                         | hit_io | hit_st | hit_ret | hit_gpr;
   wire logic ro_hit   = hit_st | hit_ret;
   wire logic refuse   = ~mapped | (pwrite & (busy | ro_hit));
   wire logic wr       = access & pwrite & ~pslverr;
   wire logic start_go = wr & hit_ctrl & pwdata[`CTRL_START];
   wire logic commit   = busy & (cnt == 3'h0);

   wire logic [31:0] rd_mux =
      hit_ctrl ? {30'h0000_0000, next_long, 1'b0} :
      hit_ins  ? instr :
      hit_off  ? {20'h0_0000, offset} :
      hit_pc   ? {10'h000, pc} :
      hit_flg  ? {24'h00_0000, flag_register} :
      hit_z    ? {16'h0000, zptr} :
      hit_io   ? {24'h00_0000, io_reg} :
      hit_st   ? {26'h000_0000, last_taken, last_cycles, 1'b0, busy} :
      hit_ret  ? {10'h000, ret_addr} :
      hit_gpr  ? {24'h00_0000, gpr[paddr[5:2]]} :
      32'h0000_0000;

   // ==========================================================
   // APB answer, zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & refuse;
         prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Software writable registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr     <= 32'h0000_0000;
         offset    <= 12'h000;
         zptr      <= 16'h0000;
         io_reg    <= 8'h00;
         next_long <= 1'b0;
      end else if (wr) begin
         if (hit_ins) instr <= pwdata;
         if (hit_off) offset <= pwdata[11:0];
         if (hit_z) zptr <= pwdata[15:0];
         if (hit_io) io_reg <= pwdata[7:0];
         if (hit_ctrl) next_long <= pwdata[`CTRL_LONG];
      end
   end

   // ==========================================================
   // Sequencer: operands latched at start, results applied on last cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= exec_pkg::st_idle;
         busy        <= 1'b0;
         cnt         <= 3'h0;
         cur_op      <= exec_pkg::xor_registers;
         cur_dst     <= 4'h0;
         lat_a       <= 8'h00;
         lat_b       <= 8'h00;
         pend_res    <= 8'h00;
         pend_flags  <= `FLAGS_RST;
         pend_pc     <= `PC_RST;
         pend_wr     <= 1'b0;
         last_cycles <= 3'h0;
         last_taken  <= 1'b0;
      end else begin
         case (state)
            exec_pkg::st_idle: begin
               if (start_go) begin
                  state       <= exec_pkg::st_exec;
                  busy        <= 1'b1;
                  cnt         <= cycles - 3'h1;               // RQ17
                  cur_op      <= dec_op;
                  cur_dst     <= dec_dst;
                  lat_a       <= op_a;
                  lat_b       <= op_b;
                  pend_res    <= alu_res;
                  pend_flags  <= alu_flags_out;
                  pend_pc     <= next_pc;
                  pend_wr     <= alu_writes;
                  last_cycles <= cycles;
                  last_taken  <= flow_taken;
               end
            end
            exec_pkg::st_exec: begin
               if (commit) begin
                  state <= exec_pkg::st_idle;
                  busy  <= 1'b0;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            default: begin
               state <= exec_pkg::st_idle;
               busy  <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Committed state: PC, flags, return address, register file
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc            <= `PC_RST;
         flag_register <= `FLAGS_RST;
         ret_addr      <= `PC_RST;
      end else if (commit) begin
         pc            <= pend_pc;
         flag_register <= pend_flags;
         if (exec_pkg::is_call_op(cur_op)) ret_addr <= pc + 22'h00_0001;
      end else if (wr) begin
         if (hit_pc) pc <= pwdata[21:0];
         if (hit_flg) flag_register <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 16; i++) gpr[i] <= 8'h00;
      end else if (commit && pend_wr) begin
         gpr[cur_dst] <= pend_res;
      end else if (wr && hit_gpr) begin
         gpr[paddr[5:2]] <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire logic is_flow = ~exec_pkg::is_logic_op(dec_op);

   AST_LOGIC_ONE_CYCLE: assert property ( // RQ1
      start_go && exec_pkg::is_logic_op(dec_op) |=> busy ##1 !busy)
      else $error("logic instruction not one cycle");
   AST_JUMP_TWO: assert property ( // RQ8
      start_go && (dec_op == exec_pkg::relative_jump || dec_op == exec_pkg::pointer_jump)
      |=> busy [*2] ##1 !busy)
      else $error("jump not two cycles");
   AST_CALL_THREE: assert property ( // RQ10
      start_go && exec_pkg::is_call_op(dec_op) |=> busy [*3] ##1 !busy)
      else $error("call not three cycles");
   AST_PTR_TARGET: assert property ( // RQ9
      start_go && dec_op == exec_pkg::pointer_jump |=> ##2 pc == {6'h00, $past(zptr, 3)})
      else $error("pointer jump target wrong");
   AST_XOR_RESULT: assert property ( // RQ1
      commit && cur_op == exec_pkg::xor_registers |=> gpr[cur_dst] == (lat_a ^ lat_b))
      else $error("xor result wrong");
   AST_ZERO_FLAG: assert property ( // RQ7
      commit && exec_pkg::is_logic_op(cur_op) && pend_wr
      |=> flag_register[`FLAG_Z] == (gpr[cur_dst] == 8'h00))
      else $error("zero flag mismatch");
   AST_CARRY_KEPT: assert property ( // RQ4
      commit && (cur_op == exec_pkg::add_one_to_register
                 || cur_op == exec_pkg::subtract_one_from_register)
      |=> flag_register[`FLAG_C] == $past(flag_register[`FLAG_C]))
      else $error("carry changed by add or subtract one");
   AST_FLOW_NO_FLAGS: assert property ( // RQ16
      start_go && is_flow |=> $stable(flag_register) [*4])
      else $error("flow instruction changed flags");
   AST_NOT_TAKEN_ONE: assert property ( // RQ17
      start_go && is_flow && !flow_taken |=> busy ##1 !busy ##0 pc == $past(pc, 2) + 22'h00_0001)
      else $error("untaken flow not one cycle");
   AST_LONG_SKIP: assert property ( // RQ11
      start_go && dec_op == exec_pkg::compare_skip_equal && flow_taken && next_long
      |=> busy [*3] ##1 !busy)
      else $error("long skip not three cycles");
   AST_APB_READY: assert property (
      setup |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   AST_REL_TARGET: assert property ( // RQ8
      start_go && dec_op == exec_pkg::relative_jump |=> ##2
      pc == $past(pc, 3) + {{10{$past(offset[11], 3)}}, $past(offset, 3)} + 22'h00_0001)
      else $error("relative jump target wrong");
   AST_REG_SKIP_SHORT: assert property ( // RQ12
      start_go && dec_op == exec_pkg::skip_if_reg_bit_high && op_a[dec_bsel] && !next_long
      |=> ##2 pc == $past(pc, 3) + 22'h00_0002)
      else $error("register skip target wrong");
   AST_BRANCH_TWO: assert property ( // RQ15
      start_go && dec_op == exec_pkg::jump_if_equal && flag_register[`FLAG_Z]
      |=> busy [*2] ##1 !busy)
      else $error("taken branch not two cycles");
   AST_BUSY_REFUSE: assert property (
      setup && pwrite && busy |=> pslverr)
      else $error("write while busy not refused");
   AST_PROBE_KEEPS: assert property ( // RQ6
      commit && cur_op == exec_pkg::probe_zero_or_negative |=> $stable(gpr[cur_dst]))
      else $error("probe changed register");

   COV_XOR: cover property (start_go && dec_op == exec_pkg::xor_registers);
   COV_BRANCH_TAKEN: cover property (start_go && dec_op == exec_pkg::jump_if_equal && flow_taken);
   COV_LONG_SKIP: cover property (start_go && flow_taken && next_long
                                  && dec_op == exec_pkg::skip_if_io_bit_high);
   COV_CALL: cover property (commit && cur_op == exec_pkg::relative_subroutine_call);

endmodule

// ===== verification/prog_mem.sv
`timescale 1ns/10ps

// ==========================================
// Program memory model
module prog_mem (
   input  wire logic [2:0]  addr,
   output logic      [31:0] word
);
   // Op from address, dst 1, src 2, mask 0x81, bit 4
   assign word = {8'h04, 8'h81, 8'h21, 5'h00, addr};
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`include "exec_defines.svh"

module tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        busy;
   logic [2:0]  pm_addr;
   logic [31:0] pm_word;
   logic [31:0] q;
   logic        e;
   int          num_errors;
   int          checks;
   int          cyc;

   logic_and_branch_execution i_logic_and_branch_execution (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
   prog_mem i_prog_mem (.addr(pm_addr), .word(pm_word));

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ==========================================
   // Checks and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ==========================================
   // Bus and execution tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         chk(0, 1, "no pready");
         final_report();
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitdone();
      cyc = 0;
      repeat (20) begin
         @(posedge pclk);
         if (busy !== 1'b1) break;
         cyc++;
      end
      if (busy !== 1'b0) begin
         chk(0, 1, "busy stuck");
         final_report();
      end
   endtask

   task automatic logic_op(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      logic       v;
      v = 1'b0;
      case (op)
         3'h0: r = a ^ b;
         3'h1: r = a | 8'h81;
         3'h2: r = a & ~8'h81;
         3'h3: begin r = a + 8'h01; v = (a == 8'h7F); end
         3'h4: begin r = a - 8'h01; v = (a == 8'h80); end
         3'h5: r = a;
         default: r = 8'h00;
      endcase
      pm_addr = op;
      apb(1'b1, 12'h044, {24'h00_0000, a});
      apb(1'b1, 12'h048, {24'h00_0000, b});
      apb(1'b1, `ADDR_FLAGS, 32'h0000_0001);
      apb(1'b1, `ADDR_INSTR, pm_word);
      apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
      waitdone();
      chk(cyc, 1, "cycles");
      apb(1'b0, 12'h044, 32'h0000_0000);
      chk(q, {24'h00_0000, r}, "result");
      apb(1'b0, `ADDR_FLAGS, 32'h0000_0000);
      chk(q, {27'h000_0000, r[7] ^ v, v, r[7], r == 8'h00, 1'b1}, "flags");
      $display("logic op %0d done", op);
   endtask

   task automatic flow(input logic [4:0] op, input logic [7:0] b, input logic [7:0] fl,
                       input logic lng, input logic [21:0] dst, input int c);
      apb(1'b1, 12'h044, 32'h0000_0010);
      apb(1'b1, 12'h048, {24'h00_0000, b});
      apb(1'b1, `ADDR_IODATA, 32'h0000_0010);
      apb(1'b1, `ADDR_FLAGS, {24'h00_0000, fl});
      apb(1'b1, `ADDR_OFFSET, 32'h0000_0FFD);
      apb(1'b1, `ADDR_ZPTR, 32'h0000_BEEF);
      apb(1'b1, `ADDR_PC, 32'h003F_0100);
      apb(1'b1, `ADDR_INSTR, {24'h04_0021, 3'h0, op});
      apb(1'b1, `ADDR_CTRL, {30'h0000_0000, lng, 1'b0});
      apb(1'b1, `ADDR_CTRL, {30'h0000_0000, lng, 1'b1});
      waitdone();
      chk(cyc, c, "cycles");
      apb(1'b0, `ADDR_PC, 32'h0000_0000);
      chk(q, {10'h000, dst}, "pc");
      apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      chk({29'h0000_0000, q[4:2]}, c, "status cycles");
      apb(1'b0, `ADDR_FLAGS, 32'h0000_0000);
      chk(q, {24'h00_0000, fl}, "flags kept");
      if (op == 5'd9 || op == 5'd10) begin
         apb(1'b0, `ADDR_RETADDR, 32'h0000_0000);
         chk(q, 32'h003F_0101, "return");
      end
      $display("flow op %0d done", op);
   endtask

   // ==========================================
   // Test sequence
   initial begin
      num_errors = 0;
      checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pm_addr = 3'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `ADDR_PC, 32'h0000_0000);
      chk(q, 32'h0000_0000, "pc reset");
      logic_op(3'h0, 8'h5A, 8'hFF);
      logic_op(3'h1, 8'h40, 8'h00);
      logic_op(3'h2, 8'h81, 8'h00);
      logic_op(3'h3, 8'h7F, 8'h00);
      logic_op(3'h4, 8'h80, 8'h00);
      logic_op(3'h5, 8'h80, 8'h00);
      logic_op(3'h6, 8'h33, 8'h00);
      flow(5'd7, 8'h10, 8'h00, 1'b0, 22'h3F_00FE, 2);
      flow(5'd8, 8'h10, 8'h00, 1'b0, 22'h00_BEEF, 2);
      flow(5'd9, 8'h10, 8'h00, 1'b0, 22'h3F_00FE, 3);
      flow(5'd10, 8'h10, 8'h00, 1'b0, 22'h00_BEEF, 3);
      flow(5'd11, 8'h10, 8'h00, 1'b0, 22'h3F_0102, 2);
      flow(5'd11, 8'h10, 8'h00, 1'b1, 22'h3F_0103, 3);
      flow(5'd11, 8'h11, 8'h00, 1'b1, 22'h3F_0101, 1);
      flow(5'd12, 8'h10, 8'h00, 1'b0, 22'h3F_0101, 1);
      flow(5'd13, 8'h10, 8'h00, 1'b0, 22'h3F_0102, 2);
      flow(5'd14, 8'h10, 8'h00, 1'b1, 22'h3F_0101, 1);
      flow(5'd15, 8'h10, 8'h00, 1'b1, 22'h3F_0103, 3);
      flow(5'd16, 8'h10, 8'h10, 1'b0, 22'h3F_00FE, 2);
      flow(5'd17, 8'h10, 8'h10, 1'b0, 22'h3F_0101, 1);
      flow(5'd18, 8'h10, 8'h02, 1'b0, 22'h3F_00FE, 2);
      flow(5'd19, 8'h10, 8'h02, 1'b0, 22'h3F_0101, 1);
      flow(5'd20, 8'h10, 8'h01, 1'b0, 22'h3F_00FE, 2);
      flow(5'd21, 8'h10, 8'h01, 1'b0, 22'h3F_0101, 1);
      flow(5'd21, 8'h10, 8'h00, 1'b0, 22'h3F_00FE, 2);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({31'h0000_0000, e}, 1, "unmapped err");
      chk(q, 32'h0000_0000, "unmapped data");
      apb(1'b1, `ADDR_STATUS, 32'h0000_001C);
      chk({31'h0000_0000, e}, 1, "status write err");
      apb(1'b1, `ADDR_INSTR, 32'h0400_2109);
      apb(1'b1, `ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, `ADDR_FLAGS, 32'h0000_00FF);
      chk({31'h0000_0000, e}, 1, "busy write err");
      waitdone();
      apb(1'b0, `ADDR_FLAGS, 32'h0000_0000);
      chk(q, 32'h0000_0000, "flags after refusal");
      $display("refusal test done");
      final_report();
   end
endmodule
